//--- rtl/cdf_pkg.sv
// cdf_pkg: shared widths, carrier types, coefficient presets and selectors
// for the codec digital filter chain; no timing constants are needed.
package cdf_pkg;

  localparam int SW = 16;
  localparam int CW = 16;
  localparam int FRAC = 14;
  localparam int ACCW = 2 * SW + 3;
  localparam int FIFO_DEPTH = 4;

  localparam logic signed [SW-1:0] SMAX = 16'sh7fff;
  localparam logic signed [SW-1:0] SMIN = 16'sh8000;

  // stereo sample, one word per channel
  typedef struct packed {
    logic signed [SW-1:0] l;
    logic signed [SW-1:0] r;
  } cdf_smp_t;

  // one biquad: y = b0 x + b1 x1 + b2 x2 - a1 y1 - a2 y2, coefficients q2.14
  typedef struct packed {
    logic signed [CW-1:0] b0;
    logic signed [CW-1:0] b1;
    logic signed [CW-1:0] b2;
    logic signed [CW-1:0] a1;
    logic signed [CW-1:0] a2;
  } cdf_coef_t;

  typedef enum logic [2:0] {
    CS_HP, CS_FX1_L, CS_FX1_R, CS_FX2_L, CS_FX2_R, CS_DEEMPH
  } cdf_csel_t;

  typedef enum logic [1:0] {HP_OFF, HP_C1, HP_C2, HP_C3} cdf_hp_t;

  localparam logic signed [CW-1:0] Q_ONE = 16'sh4000;
  localparam logic signed [CW-1:0] Q_MONE = 16'shc000;
  localparam logic signed [CW-1:0] Q_ZERO = 16'sh0000;

  localparam cdf_coef_t COEF_UNITY = '{Q_ONE, Q_ZERO, Q_ZERO, Q_ZERO, Q_ZERO};
  // first-order high-pass, pole fixed in z so the corner tracks the sample rate
  localparam cdf_coef_t HP_COEF_C1 = '{Q_ONE, Q_MONE, Q_ZERO, 16'shc008, Q_ZERO};
  localparam cdf_coef_t HP_COEF_C2 = '{Q_ONE, Q_MONE, Q_ZERO, 16'shc0a4, Q_ZERO};
  localparam cdf_coef_t HP_COEF_C3 = '{Q_ONE, Q_MONE, Q_ZERO, 16'shc148, Q_ZERO};

endpackage

//--- rtl/cdf_fifo.sv
// cdf_fifo: small flop-based fifo with valid/ready on both sides.
// assumes a single clock; depth need not be a power of two.
`timescale 1ns/10ps
`default_nettype none
module cdf_fifo
  import cdf_pkg::*;
#(
  parameter int W = 2 * SW,
  parameter int D = FIFO_DEPTH
)
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_vld,
  input wire logic [W-1:0] i_data,
  output logic o_rdy,
  output logic o_vld,
  output logic [W-1:0] o_data,
  input wire logic i_rdy
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem_r [D];
  logic [W-1:0] mem_nxt [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_rdy = (cnt_r != (AW + 1)'(D));
  assign o_vld = (cnt_r != '0);
  assign o_data = mem_r[rp_r];
  assign push = i_vld && o_rdy;
  assign pop = o_vld && i_rdy;

  always_comb
  begin
    mem_nxt = mem_r;
    wp_nxt = push ? inc(wp_r) : wp_r;
    rp_nxt = pop ? inc(rp_r) : rp_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      mem_nxt[wp_r] = i_data;
    end
    if (push && !pop)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mem_r <= '{default: '0};
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule
`default_nettype wire

//--- rtl/cdf_biquad.sv
// cdf_biquad: one stereo biquad section, direct form i, per-channel bypass.
// assumes one sample strobe per sample period; result one cycle later.
`timescale 1ns/10ps
`default_nettype none
module cdf_biquad
  import cdf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_vld,
  input wire cdf_smp_t i_smp,
  input wire cdf_coef_t i_coef_l,
  input wire cdf_coef_t i_coef_r,
  input wire logic i_en_l,
  input wire logic i_en_r,
  output logic o_vld,
  output cdf_smp_t o_smp
);

  cdf_smp_t x1_r, x2_r, y1_r, y2_r, out_r;
  cdf_smp_t x1_nxt, x2_nxt, y1_nxt, y2_nxt, out_nxt, y;
  logic vld_r, vld_nxt;

  function automatic logic signed [2*SW-1:0] mul(input logic signed [CW-1:0] c,
                                                 input logic signed [SW-1:0] s);
    logic signed [2*SW-1:0] p;
    p = c * s;
    return p;
  endfunction

  function automatic logic signed [SW-1:0] mac(input logic signed [SW-1:0] x,
      input logic signed [SW-1:0] x1, input logic signed [SW-1:0] x2,
      input logic signed [SW-1:0] y1, input logic signed [SW-1:0] y2,
      input cdf_coef_t c);
    logic signed [ACCW-1:0] acc;
    logic signed [ACCW-FRAC-1:0] q;
    acc = ACCW'(mul(c.b0, x)) + ACCW'(mul(c.b1, x1)) + ACCW'(mul(c.b2, x2))
        - ACCW'(mul(c.a1, y1)) - ACCW'(mul(c.a2, y2));
    q = acc[ACCW-1:FRAC];
    // saturate rather than wrap: a wrapped audio sample is a loud click
    if (q > SMAX)
      return SMAX;
    else if (q < SMIN)
      return SMIN;
    else
      return q[SW-1:0];
  endfunction

  // ----------------------------------------------------------------
  // section state, left and right kept apart
  // ----------------------------------------------------------------
  always_comb
  begin
    y.l = mac(i_smp.l, x1_r.l, x2_r.l, y1_r.l, y2_r.l, i_coef_l);
    y.r = mac(i_smp.r, x1_r.r, x2_r.r, y1_r.r, y2_r.r, i_coef_r);
    x1_nxt = x1_r;
    x2_nxt = x2_r;
    y1_nxt = y1_r;
    y2_nxt = y2_r;
    out_nxt = out_r;
    vld_nxt = i_vld;
    if (i_vld)
    begin
      x1_nxt = i_smp;
      x2_nxt = x1_r;
      y1_nxt = y;
      y2_nxt = y1_r;
      out_nxt.l = i_en_l ? y.l : i_smp.l;
      out_nxt.r = i_en_r ? y.r : i_smp.r;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      x1_r <= '0;
      x2_r <= '0;
      y1_r <= '0;
      y2_r <= '0;
      out_r <= '0;
      vld_r <= 1'b0;
    end
    else
    begin
      x1_r <= x1_nxt;
      x2_r <= x2_nxt;
      y1_r <= y1_nxt;
      y2_r <= y2_nxt;
      out_r <= out_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign o_smp = out_r;
  assign o_vld = vld_r;

endmodule
`default_nettype wire

//--- rtl/cdf_filter_chain.sv
// cdf_filter_chain: adc high-pass, shared two-biquad effects block and dac
// de-emphasis, with a fifo ahead of the pcm transmit side.
// assumes adc samples, pcm samples and host controls all come from logic
// on i_clk; controls are plain ports, no register bus.
//
// Functional notes
// RULE1: preset high-pass: off or three corners
// RULE2: high-pass standard preset or programmable coefficients
// RULE3: programmable high-pass only on enabled channels
// RULE4: adc: high-pass, then effects, then pcm out
// RULE5: pcm in: effects, then de-emphasis, then dac
// RULE6: effects on one path only at once
// RULE7: effects are two cascaded biquad sections
// RULE8: de-emphasis coefficients written by host
// RULE9: effects take coefficients only on host write
// RULE10: host disables effects while rewriting coefficients
// RULE11: one sample per period, channels kept separate
`timescale 1ns/10ps
`default_nettype none
module cdf_filter_chain
  import cdf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire cdf_smp_t i_adc_smp,
  input wire logic i_adc_vld,
  output logic o_adc_rdy,
  output cdf_smp_t o_pcm_tx_smp,
  output logic o_pcm_tx_vld,
  input wire logic i_pcm_tx_rdy,
  input wire cdf_smp_t i_pcm_rx_smp,
  input wire logic i_pcm_rx_vld,
  output logic o_pcm_rx_rdy,
  output cdf_smp_t o_dac_smp,
  output logic o_dac_vld,
  input wire cdf_hp_t i_hp_preset_l,
  input wire cdf_hp_t i_hp_preset_r,
  input wire logic i_hp_prog_en_l,
  input wire logic i_hp_prog_en_r,
  input wire logic i_fx_on_dac,
  input wire logic i_fx_en_l,
  input wire logic i_fx_en_r,
  input wire logic i_deemph_en,
  input wire logic i_coef_wr,
  input wire cdf_csel_t i_coef_sel,
  input wire cdf_coef_t i_coef_data,
  output logic o_fx_on_dac
);

  // ----------------------------------------------------------------
  // coefficient store
  // ----------------------------------------------------------------
  cdf_coef_t hp_coef_r, fx1_l_r, fx1_r_r, fx2_l_r, fx2_r_r, de_coef_r;
  cdf_coef_t hp_coef_nxt, fx1_l_nxt, fx1_r_nxt, fx2_l_nxt, fx2_r_nxt, de_coef_nxt;

  // only a write strobe moves a coefficient; enables play no part [RULE9]
  always_comb
  begin
    hp_coef_nxt = hp_coef_r;
    fx1_l_nxt = fx1_l_r;
    fx1_r_nxt = fx1_r_r;
    fx2_l_nxt = fx2_l_r;
    fx2_r_nxt = fx2_r_r;
    de_coef_nxt = de_coef_r;
    if (i_coef_wr)
    begin
      unique case (i_coef_sel)
        CS_HP: hp_coef_nxt = i_coef_data; // [RULE2]
        CS_FX1_L: fx1_l_nxt = i_coef_data; // [RULE9]
        CS_FX1_R: fx1_r_nxt = i_coef_data;
        CS_FX2_L: fx2_l_nxt = i_coef_data;
        CS_FX2_R: fx2_r_nxt = i_coef_data;
        CS_DEEMPH: de_coef_nxt = i_coef_data; // [RULE8]
        default: hp_coef_nxt = hp_coef_r;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hp_coef_r <= COEF_UNITY;
      fx1_l_r <= COEF_UNITY;
      fx1_r_r <= COEF_UNITY;
      fx2_l_r <= COEF_UNITY;
      fx2_r_r <= COEF_UNITY;
      de_coef_r <= COEF_UNITY;
    end
    else
    begin
      hp_coef_r <= hp_coef_nxt;
      fx1_l_r <= fx1_l_nxt;
      fx1_r_r <= fx1_r_nxt;
      fx2_l_r <= fx2_l_nxt;
      fx2_r_r <= fx2_r_nxt;
      de_coef_r <= de_coef_nxt;
    end
  end

  // ----------------------------------------------------------------
  // high-pass mode decode, per channel
  // ----------------------------------------------------------------
  function automatic cdf_coef_t hp_pick(input cdf_hp_t p, input logic prog,
                                        input cdf_coef_t pc);
    cdf_coef_t c;
    c = pc;
    if (!prog)
    begin
      unique case (p)
        HP_OFF: c = COEF_UNITY;
        HP_C1: c = HP_COEF_C1;
        HP_C2: c = HP_COEF_C2;
        HP_C3: c = HP_COEF_C3;
      endcase
    end
    return c;
  endfunction

  cdf_coef_t hp_cl, hp_cr;
  logic hp_en_l, hp_en_r;

  assign hp_cl = hp_pick(i_hp_preset_l, i_hp_prog_en_l, hp_coef_r); // [RULE1] [RULE2]
  assign hp_cr = hp_pick(i_hp_preset_r, i_hp_prog_en_r, hp_coef_r);
  // programmable filter acts only where its channel enable is set [RULE3]
  assign hp_en_l = i_hp_prog_en_l || (i_hp_preset_l != HP_OFF);
  assign hp_en_r = i_hp_prog_en_r || (i_hp_preset_r != HP_OFF);

  // ----------------------------------------------------------------
  // path ownership and one-sample-in-flight tracking
  // ----------------------------------------------------------------
  logic adc_busy_r, adc_busy_nxt, dac_busy_r, dac_busy_nxt, sel_dac_r, sel_dac_nxt;
  logic adc_go, dac_go, fifo_rdy, fifo_push, hpf_vld, fx1_vld, fx2_vld, fx_in_vld;
  logic de_in_vld;
  cdf_smp_t hpf_smp, fx1_smp, fx2_smp, fx_in_smp, de_in_smp, fifo_smp;

  // one sample per path at a time: a sample period spans far more cycles
  // than the pipeline, and the push into the fifo can then never fail
  assign o_adc_rdy = !adc_busy_r && fifo_rdy; // [RULE11]
  assign o_pcm_rx_rdy = !dac_busy_r;
  assign adc_go = i_adc_vld && o_adc_rdy;
  assign dac_go = i_pcm_rx_vld && o_pcm_rx_rdy;

  always_comb
  begin
    adc_busy_nxt = adc_busy_r;
    dac_busy_nxt = dac_busy_r;
    sel_dac_nxt = sel_dac_r;
    if (adc_go)
      adc_busy_nxt = 1'b1;
    else if (fifo_push)
      adc_busy_nxt = 1'b0;
    if (dac_go)
      dac_busy_nxt = 1'b1;
    else if (o_dac_vld)
      dac_busy_nxt = 1'b0;
    // effects change owner only with both paths empty [RULE6]
    if (!adc_busy_r && !dac_busy_r && !adc_go && !dac_go)
      sel_dac_nxt = i_fx_on_dac;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      adc_busy_r <= 1'b0;
      dac_busy_r <= 1'b0;
      sel_dac_r <= 1'b0;
    end
    else
    begin
      adc_busy_r <= adc_busy_nxt;
      dac_busy_r <= dac_busy_nxt;
      sel_dac_r <= sel_dac_nxt;
    end
  end

  assign o_fx_on_dac = sel_dac_r;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  cdf_biquad u_hpf (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_vld(adc_go),
    .i_smp(i_adc_smp),
    .i_coef_l(hp_cl),
    .i_coef_r(hp_cr),
    .i_en_l(hp_en_l),
    .i_en_r(hp_en_r),
    .o_vld(hpf_vld),
    .o_smp(hpf_smp)
  );

  // effects fed from exactly one path [RULE6] [RULE4] [RULE5]
  assign fx_in_vld = sel_dac_r ? dac_go : hpf_vld;
  assign fx_in_smp = sel_dac_r ? i_pcm_rx_smp : hpf_smp;

  cdf_biquad u_fx1 (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_vld(fx_in_vld),
    .i_smp(fx_in_smp),
    .i_coef_l(fx1_l_r),
    .i_coef_r(fx1_r_r),
    .i_en_l(i_fx_en_l),
    .i_en_r(i_fx_en_r),
    .o_vld(fx1_vld),
    .o_smp(fx1_smp)
  );

  // second section takes the first's output: responses multiply [RULE7]
  cdf_biquad u_fx2 (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_vld(fx1_vld),
    .i_smp(fx1_smp),
    .i_coef_l(fx2_l_r),
    .i_coef_r(fx2_r_r),
    .i_en_l(i_fx_en_l),
    .i_en_r(i_fx_en_r),
    .o_vld(fx2_vld),
    .o_smp(fx2_smp)
  );

  assign fifo_push = sel_dac_r ? hpf_vld : fx2_vld; // [RULE4]
  assign fifo_smp = sel_dac_r ? hpf_smp : fx2_smp;

  cdf_fifo #(
    .W(2 * SW),
    .D(FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_vld(fifo_push),
    .i_data(fifo_smp),
    .o_rdy(fifo_rdy),
    .o_vld(o_pcm_tx_vld),
    .o_data(o_pcm_tx_smp),
    .i_rdy(i_pcm_tx_rdy)
  );

  assign de_in_vld = sel_dac_r ? fx2_vld : dac_go; // [RULE5]
  assign de_in_smp = sel_dac_r ? fx2_smp : i_pcm_rx_smp;

  cdf_biquad u_deemph (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_vld(de_in_vld),
    .i_smp(de_in_smp),
    .i_coef_l(de_coef_r),
    .i_coef_r(de_coef_r),
    .i_en_l(i_deemph_en),
    .i_en_r(i_deemph_en),
    .o_vld(o_dac_vld),
    .o_smp(o_dac_smp)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic signed [SW-1:0] adc_l, hpf_l, rx_r, dac_r;
  assign adc_l = i_adc_smp.l;
  assign hpf_l = hpf_smp.l;
  assign rx_r = i_pcm_rx_smp.r;
  assign dac_r = o_dac_smp.r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_fx_pair;
    fx1_vld ##1 fx2_vld;
  endsequence

  sequence s_adc_fx;
    hpf_vld ##1 s_fx_pair;
  endsequence

  a_hp_preset_coef: assert property ( // [RULE1]
    !i_hp_prog_en_l && i_hp_preset_l == HP_C2 |-> hp_cl == HP_COEF_C2)
    else $error("preset corner coefficients wrong");

  a_hp_prog_coef: assert property ( // [RULE2]
    i_hp_prog_en_r |-> hp_cr == hp_coef_r)
    else $error("programmable high-pass not using host coefficients");

  a_hp_off_pass: assert property ( // [RULE3]
    adc_go && !i_hp_prog_en_l && i_hp_preset_l == HP_OFF |=> hpf_l == $past(adc_l))
    else $error("disabled high-pass altered the sample");

  a_adc_chain_order: assert property ( // [RULE4]
    adc_go && !sel_dac_r |=> s_adc_fx ##0 fifo_push)
    else $error("adc sample skipped a stage");

  a_dac_chain_order: assert property ( // [RULE5]
    dac_go && sel_dac_r |=> s_fx_pair ##1 o_dac_vld)
    else $error("dac sample skipped a stage");

  a_dac_deemph_pass: assert property ( // [RULE5]
    dac_go && !sel_dac_r && !i_deemph_en |=> o_dac_vld && dac_r == $past(rx_r))
    else $error("dac sample not passed through de-emphasis stage");

  a_fx_owner_hold: assert property ( // [RULE6]
    adc_busy_r || dac_busy_r |=> $stable(sel_dac_r))
    else $error("effects owner changed mid-sample");

  a_fx_one_src: assert property ( // [RULE6]
    fx_in_vld |-> (sel_dac_r ? i_pcm_rx_vld && !dac_busy_r : adc_busy_r))
    else $error("effects fed by the wrong path");

  a_fx_cascade: assert property ( // [RULE7]
    fx_in_vld |=> s_fx_pair)
    else $error("second effects section not fed by the first");

  a_de_coef_load: assert property ( // [RULE8]
    i_coef_wr && i_coef_sel == CS_DEEMPH |=> de_coef_r == $past(i_coef_data))
    else $error("de-emphasis coefficients not loaded");

  a_fx_coef_hold: assert property ( // [RULE9]
    !i_coef_wr ##1 $changed(i_fx_en_l) |-> $stable(fx1_l_r) && $stable(fx2_l_r))
    else $error("effects coefficients moved without a write");

  a_fx_coef_load: assert property ( // [RULE9]
    i_coef_wr && i_coef_sel == CS_FX2_R |=> fx2_r_r == $past(i_coef_data))
    else $error("effects coefficients not loaded on write");

  a_one_sample: assert property ( // [RULE11]
    adc_go |=> adc_busy_r && !adc_go)
    else $error("second adc sample accepted while one in flight");

endmodule
`default_nettype wire

//--- bench/cdf_pcm_sink.sv
// cdf_pcm_sink: far-side model of the pcm transmit port, queues every word taken.
// assumes the bench may stall it; ready moves on the falling edge only.
`timescale 1ns/10ps
`default_nettype none
module cdf_pcm_sink
  import cdf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_stall,
  input wire logic i_vld,
  input wire cdf_smp_t i_smp,
  output logic o_rdy
);
  cdf_smp_t got_q[$];
  cdf_smp_t smp_s;
  logic vld_s;

  initial
  begin
    o_rdy = 1'b0;
    vld_s = 1'b0;
    smp_s = '0;
  end

  // capture what stands before the edge: the fifo head moves at that edge
  always @(negedge i_clk)
  begin
    o_rdy <= i_arst_n && !i_stall;
    vld_s <= i_vld;
    smp_s <= i_smp;
  end

  always @(posedge i_clk)
    if (i_arst_n && vld_s && o_rdy)
      got_q.push_back(smp_s);
endmodule
`default_nettype wire

//--- bench/cdf_filter_chain_tb_top.sv
// cdf_filter_chain_tb_top: directed bench for the filter chain.
// assumes unity coefficients after reset and a pcm sink model on the tx side.
`timescale 1ns/10ps
`default_nettype none
module cdf_filter_chain_tb_top;
  import cdf_pkg::*;
  localparam int CEIL = 20000;
  logic i_clk = 1'b0;
  logic rst_n = 1'b0;
  cdf_smp_t adc_smp = '0;
  cdf_smp_t rx_smp = '0;
  cdf_smp_t tx_smp;
  cdf_smp_t dac_smp;
  logic adc_vld = 1'b0;
  logic rx_vld = 1'b0;
  logic prog_l = 1'b0;
  logic prog_r = 1'b0;
  logic fx_on_dac = 1'b0;
  logic fx_l = 1'b0;
  logic fx_r = 1'b0;
  logic deemph = 1'b0;
  logic coef_wr = 1'b0;
  logic stall = 1'b0;
  cdf_hp_t hp_l = HP_OFF;
  cdf_hp_t hp_r = HP_OFF;
  cdf_csel_t coef_sel = CS_HP;
  cdf_coef_t coef_data = '0;
  logic adc_rdy, tx_vld, tx_rdy, rx_rdy, dac_vld, fx_on;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  logic [15:0] pole [1:3] = '{16'h3ff8, 16'h3f5c, 16'h3eb8};

  always #12.5 i_clk = ~i_clk;

  cdf_filter_chain cdf_filter_chain_inst (.i_clk(i_clk), .i_arst_n(rst_n),
    .i_adc_smp(adc_smp), .i_adc_vld(adc_vld), .o_adc_rdy(adc_rdy),
    .o_pcm_tx_smp(tx_smp), .o_pcm_tx_vld(tx_vld), .i_pcm_tx_rdy(tx_rdy),
    .i_pcm_rx_smp(rx_smp), .i_pcm_rx_vld(rx_vld), .o_pcm_rx_rdy(rx_rdy),
    .o_dac_smp(dac_smp), .o_dac_vld(dac_vld), .i_hp_preset_l(hp_l),
    .i_hp_preset_r(hp_r), .i_hp_prog_en_l(prog_l), .i_hp_prog_en_r(prog_r),
    .i_fx_on_dac(fx_on_dac), .i_fx_en_l(fx_l), .i_fx_en_r(fx_r),
    .i_deemph_en(deemph), .i_coef_wr(coef_wr), .i_coef_sel(coef_sel),
    .i_coef_data(coef_data), .o_fx_on_dac(fx_on));

  cdf_pcm_sink cdf_pcm_sink_inst (.i_clk(i_clk), .i_arst_n(rst_n), .i_stall(stall),
    .i_vld(tx_vld), .i_smp(tx_smp), .o_rdy(tx_rdy));

  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset;
    @(negedge i_clk);
    rst_n = 1'b0;
    repeat (16) @(negedge i_clk);
    rst_n = 1'b1;
  endtask

  task automatic wr_coef(input cdf_csel_t sel, input logic signed [CW-1:0] b0);
    @(negedge i_clk);
    coef_wr = 1'b1;
    coef_sel = sel;
    coef_data = '{b0, Q_ZERO, Q_ZERO, Q_ZERO, Q_ZERO};
    @(negedge i_clk);
    coef_wr = 1'b0;
    coef_data = '1; // junk left on the bus without a strobe
  endtask

  task automatic offer_adc(input logic [31:0] s, output bit ok);
    int n;
    n = 0;
    @(negedge i_clk);
    adc_smp = s;
    adc_vld = 1'b1;
    while (adc_rdy !== 1'b1 && n < 20)
    begin
      @(negedge i_clk);
      n++;
    end
    ok = (adc_rdy === 1'b1);
    if (ok)
    begin
      @(posedge i_clk);
      @(negedge i_clk);
    end
    adc_vld = 1'b0;
  endtask

  task automatic pop_tx(input logic [31:0] exp);
    int n;
    logic [31:0] seen;
    n = 0;
    seen = 'x;
    while (cdf_pcm_sink_inst.got_q.size() == 0 && n < 40)
    begin
      @(negedge i_clk);
      n++;
    end
    if (cdf_pcm_sink_inst.got_q.size() > 0)
      seen = cdf_pcm_sink_inst.got_q.pop_front();
    chk(seen, exp);
  endtask

  // latency counted in falling edges after the taking edge
  task automatic send_rx(input logic [31:0] s, input int lat, input logic [31:0] exp);
    int n;
    n = 0;
    @(negedge i_clk);
    rx_smp = s;
    rx_vld = 1'b1;
    while (rx_rdy !== 1'b1 && n < 20)
    begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    @(negedge i_clk);
    rx_vld = 1'b0;
    n = 1;
    while (dac_vld !== 1'b1 && n < 10)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(n, lat);
    chk(dac_smp, exp);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset;
    chk({27'h0, adc_rdy, rx_rdy, tx_vld, dac_vld, fx_on}, 32'h18);
    $display("test reset done");
  endtask

  task automatic t_hp_preset;
    bit ok;
    for (int k = 1; k <= 3; k++)
    begin
      do_reset();
      hp_l = cdf_hp_t'(k);
      hp_r = HP_OFF;
      offer_adc(32'h1000_1000, ok);
      chk({31'h0, ok}, 32'h1);
      offer_adc(32'h1000_1000, ok);
      pop_tx(32'h1000_1000);
      pop_tx({pole[k] >> 2, 16'h1000});
    end
    hp_l = HP_OFF;
    $display("test hp_preset done");
  endtask

  task automatic t_hp_prog;
    bit ok;
    do_reset();
    wr_coef(CS_HP, 16'sh2000);
    prog_l = 1'b1;
    offer_adc(32'h1000_1000, ok);
    pop_tx(32'h0800_1000);
    prog_l = 1'b0;
    prog_r = 1'b1;
    offer_adc(32'h1000_1000, ok);
    pop_tx(32'h1000_0800);
    prog_r = 1'b0;
    $display("test hp_prog done");
  endtask

  task automatic t_fx_adc;
    bit ok;
    fx_l = 1'b0;
    fx_r = 1'b0;
    wr_coef(CS_FX1_L, 16'sh2000);
    wr_coef(CS_FX2_L, 16'sh2000);
    wr_coef(CS_FX1_R, 16'sh2000);
    wr_coef(CS_FX2_R, 16'sh2000);
    fx_l = 1'b1;
    fx_r = 1'b1;
    offer_adc(32'h1000_1000, ok);
    pop_tx(32'h0400_0400);
    send_rx(32'h1000_1000, 1, 32'h1000_1000);
    $display("test fx_adc done");
  endtask

  task automatic t_fx_dac;
    bit ok;
    fx_l = 1'b0;
    fx_on_dac = 1'b1;
    repeat (2) @(negedge i_clk);
    chk({31'h0, fx_on}, 32'h1);
    wr_coef(CS_DEEMPH, 16'sh2000);
    deemph = 1'b1;
    fx_l = 1'b1;
    send_rx(32'h1000_1000, 3, 32'h0200_0200);
    offer_adc(32'h1000_1000, ok);
    pop_tx(32'h1000_1000);
    fx_l = 1'b0;
    fx_r = 1'b0;
    wr_coef(CS_FX1_L, Q_ONE);
    fx_l = 1'b1;
    fx_r = 1'b1;
    send_rx(32'h1000_1000, 3, 32'h0400_0200);
    $display("test fx_dac done");
  endtask

  task automatic t_fifo;
    bit ok;
    int acc;
    acc = 0;
    ok = 1'b1;
    stall = 1'b1;
    while (ok && acc < 8)
    begin
      offer_adc({16'h0010 + 16'(acc), 16'h0020 + 16'(acc)}, ok);
      if (ok)
        acc++;
    end
    chk(acc, FIFO_DEPTH);
    chk({31'h0, tx_vld}, 32'h1);
    stall = 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++)
      pop_tx({16'h0010 + 16'(i), 16'h0020 + 16'(i)});
    repeat (2) @(negedge i_clk);
    chk({31'h0, tx_vld}, 32'h0);
    $display("test fifo done");
  endtask

  // ----
  // run control
  // ----
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      mismatches++;
      $display("[ERR] t=%0t run took too long", $time);
      give_verdict();
    end
  end

  initial
  begin
    do_reset();
    t_reset();
    t_hp_preset();
    t_hp_prog();
    t_fx_adc();
    t_fx_dac();
    t_fifo();
    give_verdict();
  end
endmodule
`default_nettype wire
